// File: rtl/smf_pkg.sv
// Constants and types shared by the serial message framer.
package smf_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] TX_TIMEOUT_DEFAULT_MS = 16'h1388;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int unsigned NUM_PORTS = 2;
	localparam int unsigned TERM_CHARS = 12;
	localparam int unsigned TERM_WORDS = 6;
	localparam int unsigned BUF_DEPTH = 2;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_TERM_MODE = 8'h17;
	localparam logic [7:0] ADDR_RTS_ON = 8'h1C;
	localparam logic [7:0] ADDR_TERM_COUNT = 8'h1F;
	localparam logic [7:0] ADDR_TERM_TABLE = 8'h20;
	localparam logic [7:0] ADDR_TERM_TABLE_LAST = 8'h25;
	localparam logic [7:0] ADDR_PACKET_LEN = 8'h26;
	localparam logic [7:0] ADDR_RX_TIMEOUT = 8'h27;
	localparam logic [7:0] ADDR_RX_GAP = 8'h28;
	localparam logic [7:0] ADDR_TX_TIMEOUT = 8'h29;
	localparam logic [7:0] ADDR_PRESEND = 8'h2A;
	localparam logic [7:0] ADDR_P1_RX_SWAP = 8'h2B;
	localparam logic [7:0] ADDR_P1_TX_SWAP = 8'h2C;
	localparam logic [7:0] ADDR_P2_RX_SWAP = 8'h2D;
	localparam logic [7:0] ADDR_P2_TX_SWAP = 8'h2E;
	localparam logic [7:0] ADDR_RX_STATUS = 8'h30;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int unsigned MODE_CHAR_BIT = 0;
	localparam int unsigned MODE_TIMEOUT_BIT = 1;
	localparam int unsigned MODE_GAP_BIT = 2;
	localparam int unsigned MODE_LENGTH_BIT = 3;
	localparam int unsigned SWAP_BIT = 0;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] TERM_COUNT_MAX = 16'h000C;

	typedef enum logic [2:0] {
		SMF_TX_IDLE,
		SMF_TX_PRE,
		SMF_TX_RTS,
		SMF_TX_SEND,
		SMF_TX_DRAIN
	} smf_tx_state_type;

endpackage

// File: rtl/smf_framer.sv
// Serial message framer: receive termination, transmit timing and byte swapping.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Twelve termination characters are held and an incoming port 2 byte is matched only against the first count entries.
// - With mode bit 3 set, a port 2 message ends once the packet length of bytes has been received.
// - With mode bit 1 set, a millisecond timer starts on the first port 2 byte and ends the message when the timeout expires.
// - With mode bit 2 set, a gap timer restarts on every port 2 byte and ends the message when the gap delay is reached.
// - A port 2 message not sent within the transmit timeout is aborted.
// - On port 2, the pre-send delay in milliseconds passes before request-to-send is raised.
// - Port 1 receive words keep arrival order with swap 0 and exchange the byte pair with swap 1.
// - Port 1 transmit words go out in order with swap 0 and with the byte pair exchanged with swap 1.
// - Port 2 receive words keep arrival order with swap 0 and exchange the byte pair with swap 1.
// - Port 2 transmit words go out in order with swap 0 and with the byte pair exchanged with swap 1.
// - The mode is bit mapped as character, timeout, gap and length enables, and zero means stream mode.
// - The character count from 0 to 12 selects the table entries and is used only with character termination.
// - After port 2 request-to-send rises, the on delay in milliseconds passes before the first byte is sent.
module smf_framer #(
	parameter int unsigned TICK_CYCLES = smf_pkg::TICK_CYCLES,
	parameter int unsigned BUF_DEPTH = smf_pkg::BUF_DEPTH
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	input wire logic [1:0] line_rx_valid,
	input wire logic [1:0][7:0] line_rx_data,
	output logic [1:0] line_rx_ready,
	output logic [1:0] host_rx_valid,
	output logic [1:0][15:0] host_rx_data,
	output logic [1:0][1:0] host_rx_nbytes,
	output logic [1:0] host_rx_last,
	input wire logic [1:0] host_rx_ready,
	input wire logic [1:0] host_tx_valid,
	input wire logic [1:0][15:0] host_tx_data,
	input wire logic [1:0][1:0] host_tx_nbytes,
	input wire logic [1:0] host_tx_last,
	output logic [1:0] host_tx_ready,
	output logic [1:0] line_tx_valid,
	output logic [1:0][7:0] line_tx_data,
	input wire logic [1:0] line_tx_ready,
	output logic [1:0] rts,
	output logic [1:0] tx_abort
);

	localparam int unsigned PW = $clog2(BUF_DEPTH);
	localparam int unsigned TW = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2 || BUF_DEPTH < 2 || (1 << PW) != BUF_DEPTH) begin : g_bad_param
		$error("smf_framer: unsupported TICK_CYCLES or BUF_DEPTH");
	end

	function automatic logic [15:0] smf_pair(input logic [7:0] first, input logic [7:0] second, input logic swap);
		smf_pair = swap ? {second, first} : {first, second};
	endfunction

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic [15:0] term_mode;
	logic [15:0] rts_on;
	logic [15:0] term_char_count;
	logic [15:0] term_table [0:smf_pkg::TERM_WORDS-1];
	logic [15:0] packet_length;
	logic [15:0] rx_timeout;
	logic [15:0] rx_gap_delay;
	logic [15:0] tx_timeout;
	logic [15:0] presend_delay;
	logic [15:0] p1_rx_swap;
	logic [15:0] p1_tx_swap;
	logic [15:0] p2_rx_swap;
	logic [15:0] p2_tx_swap;
	logic [1:0] rx_lost;
	logic [15:0] rd_value;
	logic [2:0] tbl_idx;
	logic tbl_hit;
	logic [1:0] lost_set;

	assign tbl_idx = 3'(cfg_addr - smf_pkg::ADDR_TERM_TABLE);
	assign tbl_hit = cfg_addr >= smf_pkg::ADDR_TERM_TABLE && cfg_addr <= smf_pkg::ADDR_TERM_TABLE_LAST;
	assign lost_set = line_rx_valid & ~line_rx_ready;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			term_mode <= smf_pkg::REG_RESET;
			rts_on <= smf_pkg::REG_RESET;
			term_char_count <= smf_pkg::REG_RESET;
			packet_length <= smf_pkg::REG_RESET;
			rx_timeout <= smf_pkg::REG_RESET;
			rx_gap_delay <= smf_pkg::REG_RESET;
			tx_timeout <= smf_pkg::REG_RESET;
			presend_delay <= smf_pkg::REG_RESET;
			p1_rx_swap <= smf_pkg::REG_RESET;
			p1_tx_swap <= smf_pkg::REG_RESET;
			p2_rx_swap <= smf_pkg::REG_RESET;
			p2_tx_swap <= smf_pkg::REG_RESET;
			for (int i = 0; i < smf_pkg::TERM_WORDS; i++) begin
				term_table[i] <= smf_pkg::REG_RESET;
			end
		end else if (cfg_wr) begin
			if (tbl_hit) begin
				term_table[tbl_idx] <= cfg_wdata;
			end
			case (cfg_addr)
				smf_pkg::ADDR_TERM_MODE: term_mode <= cfg_wdata;
				smf_pkg::ADDR_RTS_ON: rts_on <= cfg_wdata;
				smf_pkg::ADDR_TERM_COUNT: term_char_count <= cfg_wdata;
				smf_pkg::ADDR_PACKET_LEN: packet_length <= cfg_wdata;
				smf_pkg::ADDR_RX_TIMEOUT: rx_timeout <= cfg_wdata;
				smf_pkg::ADDR_RX_GAP: rx_gap_delay <= cfg_wdata;
				smf_pkg::ADDR_TX_TIMEOUT: tx_timeout <= cfg_wdata;
				smf_pkg::ADDR_PRESEND: presend_delay <= cfg_wdata;
				smf_pkg::ADDR_P1_RX_SWAP: p1_rx_swap <= cfg_wdata;
				smf_pkg::ADDR_P1_TX_SWAP: p1_tx_swap <= cfg_wdata;
				smf_pkg::ADDR_P2_RX_SWAP: p2_rx_swap <= cfg_wdata;
				smf_pkg::ADDR_P2_TX_SWAP: p2_tx_swap <= cfg_wdata;
				default: ;
			endcase
		end
	end

	// Lost bytes are sticky; a new loss wins over a write-one clear.
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rx_lost <= 2'h0;
		end else if (cfg_wr && cfg_addr == smf_pkg::ADDR_RX_STATUS) begin
			rx_lost <= (rx_lost & ~cfg_wdata[1:0]) | lost_set;
		end else begin
			rx_lost <= rx_lost | lost_set;
		end
	end

	always_comb begin
		rd_value = 16'h0000;
		if (tbl_hit) begin
			rd_value = term_table[tbl_idx];
		end
		case (cfg_addr)
			smf_pkg::ADDR_TERM_MODE: rd_value = term_mode;
			smf_pkg::ADDR_RTS_ON: rd_value = rts_on;
			smf_pkg::ADDR_TERM_COUNT: rd_value = term_char_count;
			smf_pkg::ADDR_PACKET_LEN: rd_value = packet_length;
			smf_pkg::ADDR_RX_TIMEOUT: rd_value = rx_timeout;
			smf_pkg::ADDR_RX_GAP: rd_value = rx_gap_delay;
			smf_pkg::ADDR_TX_TIMEOUT: rd_value = tx_timeout;
			smf_pkg::ADDR_PRESEND: rd_value = presend_delay;
			smf_pkg::ADDR_P1_RX_SWAP: rd_value = p1_rx_swap;
			smf_pkg::ADDR_P1_TX_SWAP: rd_value = p1_tx_swap;
			smf_pkg::ADDR_P2_RX_SWAP: rd_value = p2_rx_swap;
			smf_pkg::ADDR_P2_TX_SWAP: rd_value = p2_tx_swap;
			smf_pkg::ADDR_RX_STATUS: rd_value = {14'h0000, rx_lost};
			default: ;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cfg_rdata <= 16'h0000;
		end else if (cfg_rd) begin
			cfg_rdata <= rd_value;
		end
	end

	// ************************************************************
	// Millisecond tick
	// ************************************************************
	logic [TW-1:0] tick_cnt;
	logic tick;

	assign tick = tick_cnt == TW'(TICK_CYCLES - 1);

	always_ff @(posedge mclk) begin
		if (!rstn || tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	// ************************************************************
	// Port 2 receive termination
	// ************************************************************
	logic mode_ok;
	logic char_en;
	logic len_en;
	logic to_en;
	logic gap_en;
	logic [smf_pkg::TERM_CHARS-1:0] char_hit;
	logic msg_active;
	logic [15:0] byte_cnt;
	logic [15:0] to_cnt;
	logic [15:0] gap_cnt;
	logic timer_exp;
	logic [1:0] rx_acc;
	logic [1:0] byte_end;
	logic [1:0] timer_end;
	logic [1:0] end_done;

	assign mode_ok = term_mode[15:4] == 12'h000;
	assign char_en = mode_ok && term_mode[smf_pkg::MODE_CHAR_BIT] && term_char_count <= smf_pkg::TERM_COUNT_MAX;
	assign len_en = mode_ok && term_mode[smf_pkg::MODE_LENGTH_BIT] && packet_length != 16'h0000;
	assign to_en = mode_ok && term_mode[smf_pkg::MODE_TIMEOUT_BIT] && rx_timeout != 16'h0000;
	assign gap_en = mode_ok && term_mode[smf_pkg::MODE_GAP_BIT] && rx_gap_delay != 16'h0000;

	for (genvar i = 0; i < smf_pkg::TERM_CHARS; i++) begin : g_match
		assign char_hit[i] = 16'(i) < term_char_count && term_table[i / 2][(i % 2) * 8 +: 8] == line_rx_data[1];
	end

	assign timer_exp = msg_active && ((to_en && to_cnt >= rx_timeout) || (gap_en && gap_cnt >= rx_gap_delay));
	assign byte_end[0] = 1'b0;
	assign timer_end[0] = 1'b0;
	assign byte_end[1] = (char_en && |char_hit) || (len_en && byte_cnt + 16'h0001 >= packet_length) || timer_exp;
	assign timer_end[1] = timer_exp;

	always_ff @(posedge mclk) begin
		if (!rstn || end_done[1]) begin
			msg_active <= 1'b0;
			byte_cnt <= 16'h0000;
			to_cnt <= 16'h0000;
			gap_cnt <= 16'h0000;
		end else begin
			if (rx_acc[1]) begin
				msg_active <= 1'b1;
				byte_cnt <= byte_cnt + {15'h0000, byte_cnt != 16'hFFFF};
				gap_cnt <= 16'h0000;
			end else if (tick && msg_active) begin
				gap_cnt <= gap_cnt + {15'h0000, gap_cnt != 16'hFFFF};
			end
			if (tick && msg_active) begin
				to_cnt <= to_cnt + {15'h0000, to_cnt != 16'hFFFF};
			end
		end
	end

	// ************************************************************
	// Receive pairing, swap and buffer, one per port
	// ************************************************************
	for (genvar p = 0; p < smf_pkg::NUM_PORTS; p++) begin : g_rx
		logic [18:0] buf_mem [0:BUF_DEPTH-1];
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
		logic [7:0] half;
		logic have_half;
		logic swap;
		logic full;
		logic push;
		logic pop;
		logic tend;
		logic [15:0] word;
		logic [1:0] nbytes;

		assign swap = (p == 1) ? p2_rx_swap[smf_pkg::SWAP_BIT] : p1_rx_swap[smf_pkg::SWAP_BIT];
		assign full = cnt == (PW + 1)'(BUF_DEPTH);
		assign line_rx_ready[p] = !full;
		assign rx_acc[p] = line_rx_valid[p] && !full;
		assign tend = !line_rx_valid[p] && !full && timer_end[p];
		assign end_done[p] = (rx_acc[p] && byte_end[p]) || tend;
		assign push = (rx_acc[p] && (have_half || byte_end[p])) || tend;
		assign pop = host_rx_valid[p] && host_rx_ready[p];
		assign word = (rx_acc[p] && have_half) ? smf_pair(half, line_rx_data[p], swap) :
			rx_acc[p] ? {line_rx_data[p], 8'h00} : {have_half ? half : 8'h00, 8'h00};
		assign nbytes = (rx_acc[p] && have_half) ? 2'h2 : (rx_acc[p] || have_half) ? 2'h1 : 2'h0;
		assign host_rx_valid[p] = cnt != '0;
		assign {host_rx_last[p], host_rx_nbytes[p], host_rx_data[p]} = buf_mem[rp];

		always_ff @(posedge mclk) begin
			if (!rstn) begin
				have_half <= 1'b0;
				half <= 8'h00;
			end else if (rx_acc[p] && !have_half && !byte_end[p]) begin
				have_half <= 1'b1;
				half <= line_rx_data[p];
			end else if (push) begin
				have_half <= 1'b0;
			end
		end

		always_ff @(posedge mclk) begin
			if (!rstn) begin
				wp <= '0;
				rp <= '0;
				cnt <= '0;
				for (int i = 0; i < BUF_DEPTH; i++) begin
					buf_mem[i] <= 19'h00000;
				end
			end else begin
				if (push) begin
					buf_mem[wp] <= {end_done[p], nbytes, word};
					wp <= wp + 1'b1;
				end
				if (pop) begin
					rp <= rp + 1'b1;
				end
				cnt <= cnt + (PW + 1)'(push) - (PW + 1)'(pop);
			end
		end
	end

	// ************************************************************
	// Transmit timing, swap and serialiser, one per port
	// ************************************************************
	for (genvar p = 0; p < smf_pkg::NUM_PORTS; p++) begin : g_tx
		smf_pkg::smf_tx_state_type state;
		logic [15:0] wait_cnt;
		logic [15:0] tmo_cnt;
		logic [15:0] pre_lim;
		logic [15:0] rts_lim;
		logic [15:0] tmo_lim;
		logic [7:0] second;
		logic rem;
		logic cur_last;
		logic swap;
		logic two;
		logic busy;
		logic expired;
		logic [15:0] pair;

		assign pre_lim = (p == 1) ? presend_delay : 16'h0000;
		assign rts_lim = (p == 1) ? rts_on : 16'h0000;
		assign tmo_lim = (tx_timeout == 16'h0000) ? smf_pkg::TX_TIMEOUT_DEFAULT_MS : tx_timeout;
		assign swap = (p == 1) ? p2_tx_swap[smf_pkg::SWAP_BIT] : p1_tx_swap[smf_pkg::SWAP_BIT];
		assign two = host_tx_nbytes[p] != 2'h1;
		assign pair = smf_pair(host_tx_data[p][15:8], host_tx_data[p][7:0], swap && two);
		assign busy = state == smf_pkg::SMF_TX_PRE || state == smf_pkg::SMF_TX_RTS || state == smf_pkg::SMF_TX_SEND;
		assign expired = (p == 1) && busy && tmo_cnt >= tmo_lim;
		assign host_tx_ready[p] = (state == smf_pkg::SMF_TX_SEND && !line_tx_valid[p]) || state == smf_pkg::SMF_TX_DRAIN;

		always_ff @(posedge mclk) begin
			if (!rstn) begin
				state <= smf_pkg::SMF_TX_IDLE;
				wait_cnt <= 16'h0000;
				tmo_cnt <= 16'h0000;
				second <= 8'h00;
				rem <= 1'b0;
				cur_last <= 1'b0;
				rts[p] <= 1'b0;
				tx_abort[p] <= 1'b0;
				line_tx_valid[p] <= 1'b0;
				line_tx_data[p] <= 8'h00;
			end else begin
				tx_abort[p] <= 1'b0;
				if (tick && busy && tmo_cnt != 16'hFFFF) begin
					tmo_cnt <= tmo_cnt + 16'h0001;
				end
				case (state)
					smf_pkg::SMF_TX_IDLE: begin
						if (host_tx_valid[p]) begin
							state <= smf_pkg::SMF_TX_PRE;
							wait_cnt <= 16'h0000;
							tmo_cnt <= 16'h0000;
						end
					end
					smf_pkg::SMF_TX_PRE: begin
						if (wait_cnt >= pre_lim) begin
							state <= smf_pkg::SMF_TX_RTS;
							rts[p] <= 1'b1;
							wait_cnt <= 16'h0000;
						end else if (tick) begin
							wait_cnt <= wait_cnt + 16'h0001;
						end
					end
					smf_pkg::SMF_TX_RTS: begin
						if (wait_cnt >= rts_lim) begin
							state <= smf_pkg::SMF_TX_SEND;
						end else if (tick) begin
							wait_cnt <= wait_cnt + 16'h0001;
						end
					end
					smf_pkg::SMF_TX_SEND: begin
						if (host_tx_valid[p] && !line_tx_valid[p]) begin
							line_tx_data[p] <= pair[15:8];
							second <= pair[7:0];
							rem <= two;
							cur_last <= host_tx_last[p];
							line_tx_valid[p] <= 1'b1;
						end else if (line_tx_valid[p] && line_tx_ready[p]) begin
							if (rem) begin
								line_tx_data[p] <= second;
								rem <= 1'b0;
							end else begin
								line_tx_valid[p] <= 1'b0;
								if (cur_last) begin
									state <= smf_pkg::SMF_TX_IDLE;
									rts[p] <= 1'b0;
								end
							end
						end
					end
					smf_pkg::SMF_TX_DRAIN: begin
						if (host_tx_valid[p] && host_tx_last[p]) begin
							state <= smf_pkg::SMF_TX_IDLE;
						end
					end
					default: state <= smf_pkg::SMF_TX_IDLE;
				endcase
				if (expired) begin
					tx_abort[p] <= 1'b1;
					rts[p] <= 1'b0;
					line_tx_valid[p] <= 1'b0;
					// A last word taken on the expiry edge must not leave the port draining.
					state <= ((line_tx_valid[p] && cur_last) || (host_tx_valid[p] && host_tx_ready[p] && host_tx_last[p])) ?
						smf_pkg::SMF_TX_IDLE : smf_pkg::SMF_TX_DRAIN;
				end
			end
		end
	end

endmodule

`default_nettype wire

// File: dv/smf_line_partner.sv
// Behavioural serial device on the far side of one framer port.
`timescale 1ns/1ps
`default_nettype none
module smf_line_partner (
	input wire logic mclk,
	input wire logic slow,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic [7:0] got[$];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'hFF;
		tx_ready = 1'b0;
	end
	// A slow device accepts a byte only every other cycle.
	always @(negedge mclk) tx_ready <= slow ? ~tx_ready : 1'b1;
	always @(posedge mclk) if (tx_valid && tx_ready) got.push_back(tx_data);
	// Bytes go back to back; the released data line shows the inverse of the last byte.
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			rx_valid = 1'b1;
			rx_data = b[i];
			@(negedge mclk);
		end
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule
`default_nettype wire

// File: dv/smf_framer_properties.sv
// Concurrent checks on the framer's ports.
`timescale 1ns/1ps
`default_nettype none
module smf_framer_properties #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cfg_rd,
	input wire logic [15:0] cfg_rdata,
	input wire logic [1:0] host_rx_valid,
	input wire logic [1:0][15:0] host_rx_data,
	input wire logic [1:0][1:0] host_rx_nbytes,
	input wire logic [1:0] host_rx_last,
	input wire logic [1:0] host_rx_ready,
	input wire logic [1:0] host_tx_valid,
	input wire logic [1:0] host_tx_ready,
	input wire logic [1:0] line_tx_valid,
	input wire logic [1:0][7:0] line_tx_data,
	input wire logic [1:0] line_tx_ready,
	input wire logic [1:0] rts,
	input wire logic [1:0] tx_abort
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
		else $error("read data changed without a read");
	chk_odd_byte: assert property (host_rx_valid[1] && host_rx_nbytes[1] == 2'h1 |-> host_rx_data[1][7:0] == 8'h00)
		else $error("single byte word has a nonzero low byte");
	chk_empty_end: assert property (host_rx_valid[1] && host_rx_nbytes[1] == 2'h0 |-> host_rx_last[1])
		else $error("empty word does not end a message");
	chk_port1_stream: assert property (host_rx_valid[0] |-> !host_rx_last[0])
		else $error("port 1 marked a message end");
	chk_abort_pulse: assert property (tx_abort != 2'h0 |-> tx_abort == 2'h2 ##1 tx_abort == 2'h0)
		else $error("abort is not a single pulse on port 2");
	chk_take_byte: assert property (host_tx_valid[0] && host_tx_ready[0] |=> line_tx_valid[0])
		else $error("taken word gave no line byte");
	chk_tx1_hold: assert property (line_tx_valid[0] && !line_tx_ready[0] |=> line_tx_valid[0] && $stable(line_tx_data[0]))
		else $error("port 1 line byte not held");
	chk_tx2_hold: assert property (line_tx_valid[1] && !line_tx_ready[1] |=>
		tx_abort[1] || (line_tx_valid[1] && $stable(line_tx_data[1])))
		else $error("port 2 line byte not held");
	chk_rx1_hold: assert property (host_rx_valid[0] && !host_rx_ready[0] |=> host_rx_valid[0] && $stable(host_rx_data[0]))
		else $error("port 1 host word not held");
	chk_rx2_hold: assert property (host_rx_valid[1] && !host_rx_ready[1] |=> host_rx_valid[1] && $stable(host_rx_data[1]))
		else $error("port 2 host word not held");
	chk_rts_first: assert property ($rose(rts[1]) |-> !line_tx_valid[1])
		else $error("data went out with request-to-send");
	cover property (host_rx_valid[1] && host_rx_last[1] && host_rx_ready[1]);
	cover property (tx_abort[1]);
	cover property (line_tx_valid[1] && !line_tx_ready[1]);
endmodule
bind smf_framer smf_framer_properties #(.TICK_CYCLES(TICK_CYCLES)) smf_framer_properties_inst (.mclk(mclk),
	.rstn(rstn), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data),
	.host_rx_nbytes(host_rx_nbytes), .host_rx_last(host_rx_last), .host_rx_ready(host_rx_ready),
	.host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready), .line_tx_valid(line_tx_valid),
	.line_tx_data(line_tx_data), .line_tx_ready(line_tx_ready), .rts(rts), .tx_abort(tx_abort));
`default_nettype wire

// File: dv/smf_framer_bench.sv
// Self-checking bench for the serial message framer.
`timescale 1ns/1ps
`default_nettype none
module smf_framer_bench;
	logic mclk, rstn, cfg_wr, cfg_rd, slow;
	logic [7:0] cfg_addr;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic [1:0] line_rx_ready, host_rx_valid, host_rx_last, host_rx_ready, host_tx_valid;
	logic [1:0] host_tx_last, host_tx_ready, line_tx_valid, rts, tx_abort;
	logic [1:0][7:0] line_tx_data;
	wire logic [1:0] line_rx_valid, line_tx_ready;
	wire logic [1:0][7:0] line_rx_data;
	logic [1:0][15:0] host_rx_data, host_tx_data;
	logic [1:0][1:0] host_rx_nbytes, host_tx_nbytes;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	smf_framer #(.TICK_CYCLES(10)) smf_framer_inst (.mclk(mclk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .line_rx_valid(line_rx_valid),
		.line_rx_data(line_rx_data), .line_rx_ready(line_rx_ready), .host_rx_valid(host_rx_valid),
		.host_rx_data(host_rx_data), .host_rx_nbytes(host_rx_nbytes), .host_rx_last(host_rx_last),
		.host_rx_ready(host_rx_ready), .host_tx_valid(host_tx_valid), .host_tx_data(host_tx_data),
		.host_tx_nbytes(host_tx_nbytes), .host_tx_last(host_tx_last), .host_tx_ready(host_tx_ready),
		.line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data), .line_tx_ready(line_tx_ready), .rts(rts),
		.tx_abort(tx_abort));
	smf_line_partner smf_line_partner_inst[1:0] (.mclk(mclk), .slow(slow), .rx_valid(line_rx_valid),
		.rx_data(line_rx_data), .tx_valid(line_tx_valid), .tx_data(line_tx_data), .tx_ready(line_tx_ready));
	// ****************************************
	// Clock, timeout and shared tasks
	// ****************************************
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (err_total == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic do_reset();
		rstn = 1'b0;
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge mclk);
		cfg_wr = 1'b0;
		@(negedge mclk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] d);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge mclk);
		cfg_rd = 1'b0;
		cmp({4'h0, cfg_rdata}, {4'h0, d});
		@(negedge mclk);
	endtask
	task automatic line(input int p, input logic [7:0] b[$]);
		if (p == 0) smf_line_partner_inst[0].send(b);
		else smf_line_partner_inst[1].send(b);
	endtask
	function automatic int nb(input int p);
		return p ? smf_line_partner_inst[1].got.size() : smf_line_partner_inst[0].got.size();
	endfunction
	task automatic wait_rx(input int p, output int t);
		t = 0;
		while (host_rx_valid[p] !== 1'b1 && t < 300) begin
			@(negedge mclk);
			t++;
		end
	endtask
	task automatic pop(input int p, input logic [15:0] d, input logic [1:0] n, input logic l);
		int t;
		wait_rx(p, t);
		cmp({host_rx_valid[p], host_rx_last[p], host_rx_nbytes[p], host_rx_data[p]}, {1'b1, l, n, d});
		host_rx_ready[p] = 1'b1;
		@(negedge mclk);
		host_rx_ready[p] = 1'b0;
		@(negedge mclk);
	endtask
	// The word is withdrawn one edge after the edge that took it.
	task automatic send_tx(input int p, input logic [15:0] w, output int tr, output int td, output logic ab);
		logic pend;
		int n;
		pend = 1'b0;
		ab = 1'b0;
		tr = -1;
		td = -1;
		n = 0;
		if (p == 0) smf_line_partner_inst[0].got.delete();
		else smf_line_partner_inst[1].got.delete();
		host_tx_valid[p] = 1'b1;
		host_tx_data[p] = w;
		host_tx_nbytes[p] = 2'h2;
		host_tx_last[p] = 1'b1;
		while (n < 500 && (host_tx_valid[p] || (nb(p) < 2 && !ab))) begin
			@(negedge mclk);
			n++;
			if (rts[p] === 1'b1 && tr < 0) tr = n;
			if (line_tx_valid[p] === 1'b1 && td < 0) td = n;
			if (tx_abort[p] === 1'b1) ab = 1'b1;
			if (pend) host_tx_valid[p] = 1'b0;
			pend = host_tx_valid[p] && host_tx_ready[p] === 1'b1;
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		logic [7:0] a;
		for (int i = 0; i < 11; i++) begin
			a = 8'h20 + i[7:0];
			rdchk(a, 16'h0000);
			wr(a, {8'hC3, a});
			rdchk(a, {8'hC3, a});
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h2B + i[7:0], 16'h0001);
			rdchk(8'h2B + i[7:0], 16'h0001);
		end
		wr(8'h1F, 16'h000C);
		rdchk(8'h1F, 16'h000C);
		wr(8'h17, 16'h000F);
		rdchk(8'h17, 16'h000F);
		wr(8'h31, 16'hFFFF);
		rdchk(8'h31, 16'h0000);
		do_reset();
		rdchk(8'h20, 16'h0000);
	endtask
	task automatic t_rx_swap();
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 2; s++) begin
				wr(p ? 8'h2D : 8'h2B, {15'h0, s[0]});
				line(p, '{8'h12, 8'h34});
				pop(p, s ? 16'h3412 : 16'h1234, 2'h2, 1'b0);
			end
		end
	endtask
	// The host stalls while the two-word buffer fills and refuses a fifth byte.
	task automatic t_fill();
		do_reset();
		line(0, '{8'h21, 8'h22, 8'h23, 8'h24});
		cmp({19'h0, line_rx_ready[0]}, 20'h0);
		@(negedge mclk);
		line(0, '{8'h25});
		rdchk(8'h30, 16'h0001);
		wr(8'h30, 16'h0001);
		rdchk(8'h30, 16'h0000);
		pop(0, 16'h2122, 2'h2, 1'b0);
		pop(0, 16'h2324, 2'h2, 1'b0);
		cmp({19'h0, line_rx_ready[0]}, 20'h1);
	endtask
	task automatic t_len();
		do_reset();
		wr(8'h17, 16'h0008);
		wr(8'h26, 16'h0003);
		for (int k = 0; k < 2; k++) begin
			line(1, '{8'hA1, 8'hA2, 8'hA3});
			pop(1, 16'hA1A2, 2'h2, 1'b0);
			pop(1, 16'hA300, 2'h1, 1'b1);
		end
	endtask
	task automatic t_char();
		do_reset();
		wr(8'h17, 16'h0001);
		wr(8'h1F, 16'h0002);
		wr(8'h20, 16'h0D0A);
		wr(8'h21, 16'h0055);
		line(1, '{8'h41, 8'h55, 8'h42, 8'h0D});
		pop(1, 16'h4155, 2'h2, 1'b0);
		pop(1, 16'h420D, 2'h2, 1'b1);
	endtask
	task automatic t_timer();
		int t;
		logic [7:0] b;
		do_reset();
		wr(8'h17, 16'h0002);
		wr(8'h27, 16'h0002);
		line(1, '{8'h61});
		wait_rx(1, t);
		cmp({19'h0, t > 8 && t < 24}, 20'h1);
		pop(1, 16'h6100, 2'h1, 1'b1);
		wr(8'h17, 16'h0004);
		wr(8'h28, 16'h0002);
		for (int k = 0; k < 2; k++) begin
			b = k ? 8'h73 : 8'h71;
			repeat (5) @(negedge mclk);
			line(1, '{b});
			repeat (6) @(negedge mclk);
			line(1, '{b + 8'h01});
			pop(1, {b, b + 8'h01}, 2'h2, 1'b0);
		end
		repeat (5) @(negedge mclk);
		line(1, '{8'h75, 8'h76});
		pop(1, 16'h7576, 2'h2, 1'b0);
		wait_rx(1, t);
		cmp({19'h0, t > 8 && t < 24}, 20'h1);
		pop(1, 16'h0000, 2'h0, 1'b1);
	endtask
	task automatic t_tx();
		int tr, td;
		logic ab;
		do_reset();
		wr(8'h2C, 16'h0001);
		send_tx(0, 16'hC1C2, tr, td, ab);
		cmp({4'h0, smf_line_partner_inst[0].got[0], smf_line_partner_inst[0].got[1]}, 20'h0C2C1);
		wr(8'h2A, 16'h0003);
		wr(8'h1C, 16'h0002);
		slow = 1'b1;
		send_tx(1, 16'hD1D2, tr, td, ab);
		cmp({4'h0, smf_line_partner_inst[1].got[0], smf_line_partner_inst[1].got[1]}, 20'h0D1D2);
		cmp({19'h0, tr >= 20 && td - tr >= 10}, 20'h1);
		slow = 1'b0;
		wr(8'h29, 16'h0001);
		send_tx(1, 16'hE1E2, tr, td, ab);
		cmp({18'h0, ab, td < 0}, 20'h3);
	endtask
	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 16'h0000;
		slow = 1'b0;
		host_rx_ready = 2'h0;
		host_tx_valid = 2'h0;
		host_tx_data = 32'h0;
		host_tx_nbytes = 4'h0;
		host_tx_last = 2'h0;
		do_reset();
		t_regs();
		t_rx_swap();
		t_fill();
		t_len();
		t_char();
		t_timer();
		t_tx();
		complete_run();
	end
endmodule
`default_nettype wire
